// *** rtl/bms_pkg.sv ***
// Purpose: shared constants for the bridge mode strap and pin config block
// Assumes: single 250 MHz clock, synchronous active-high reset
// Notes: tap state codes follow a gray order along the usual walk
package bms_pkg;
  localparam int BMS_GPIO_COUNT = 4;       // general-purpose pins
  localparam int BMS_IR_WIDTH = 4;         // instruction register width
  localparam int BMS_DR_WIDTH = 8;         // data scan register width
  localparam logic BMS_IFACE_EEPROM = 1'h0; // strap low: eeprom master over i2c
  localparam logic BMS_IFACE_SMBUS = 1'h1;  // strap high: smbus slave
  localparam logic BMS_DIR_FORWARD = 1'h0;  // strap low: forward bridge
  localparam logic BMS_DIR_REVERSE = 1'h1;  // strap high: reverse bridge
  localparam logic [3:0] BMS_IR_RESET = 4'h1; // instruction loaded on capture/reset
  localparam logic [3:0] BMS_IR_BYPASS = 4'hf; // bypass instruction code
  // tap controller states
  typedef enum logic [3:0] {
    BMS_TEST_RESET = 4'h0,
    BMS_RUN_IDLE = 4'h1,
    BMS_SEL_DR = 4'h3,
    BMS_CAP_DR = 4'h2,
    BMS_SHIFT_DR = 4'h6,
    BMS_EXIT1_DR = 4'h7,
    BMS_PAUSE_DR = 4'h5,
    BMS_EXIT2_DR = 4'h4,
    BMS_UPD_DR = 4'hc,
    BMS_SEL_IR = 4'hd,
    BMS_CAP_IR = 4'hf,
    BMS_SHIFT_IR = 4'he,
    BMS_EXIT1_IR = 4'ha,
    BMS_PAUSE_IR = 4'hb,
    BMS_EXIT2_IR = 4'h9,
    BMS_UPD_IR = 4'h8
  } bms_tap_t;
endpackage

// *** rtl/bms_tap.sv ***
// Purpose: test access port controller with instruction and data scan chains
// Assumes: test clock arrives as an ordinary input sampled on the bridge clock
// Notes: acts on the rising edge of the sampled test clock
`timescale 1ns/1ps
module bms_tap
  import bms_pkg::*;
#(
  parameter int IR_WIDTH = BMS_IR_WIDTH,
  parameter int DR_WIDTH = BMS_DR_WIDTH
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic testClock,
  input wire logic testModeSelect,
  input wire logic testDataIn,
  input wire logic testReset_n,
  output logic testDataOut,
  output bms_tap_t tapState
);

  ////////////////////////////////////////////////////////////////////////
  logic prevTck; // last sampled test clock, for edge detection
  logic [IR_WIDTH-1:0] irShift; // instruction shift stage
  logic [IR_WIDTH-1:0] irHold; // active instruction
  logic [DR_WIDTH-1:0] drShift; // data scan chain
  logic next_prevTck;
  logic [IR_WIDTH-1:0] next_irShift;
  logic [IR_WIDTH-1:0] next_irHold;
  logic [DR_WIDTH-1:0] next_drShift;
  logic next_testDataOut;
  bms_tap_t next_tapState;
  logic tckRise; // one-cycle pulse on rising test clock

  assign tckRise = testClock && !prevTck;

  // standard tap transition function, steered by tms
  function automatic bms_tap_t tapNext(input bms_tap_t s, input logic m);
    unique case (s)
      BMS_TEST_RESET: tapNext = m ? BMS_TEST_RESET : BMS_RUN_IDLE;
      BMS_RUN_IDLE: tapNext = m ? BMS_SEL_DR : BMS_RUN_IDLE;
      BMS_SEL_DR: tapNext = m ? BMS_SEL_IR : BMS_CAP_DR;
      BMS_CAP_DR: tapNext = m ? BMS_EXIT1_DR : BMS_SHIFT_DR;
      BMS_SHIFT_DR: tapNext = m ? BMS_EXIT1_DR : BMS_SHIFT_DR;
      BMS_EXIT1_DR: tapNext = m ? BMS_UPD_DR : BMS_PAUSE_DR;
      BMS_PAUSE_DR: tapNext = m ? BMS_EXIT2_DR : BMS_PAUSE_DR;
      BMS_EXIT2_DR: tapNext = m ? BMS_UPD_DR : BMS_SHIFT_DR;
      BMS_UPD_DR: tapNext = m ? BMS_SEL_DR : BMS_RUN_IDLE;
      BMS_SEL_IR: tapNext = m ? BMS_TEST_RESET : BMS_CAP_IR;
      BMS_CAP_IR: tapNext = m ? BMS_EXIT1_IR : BMS_SHIFT_IR;
      BMS_SHIFT_IR: tapNext = m ? BMS_EXIT1_IR : BMS_SHIFT_IR;
      BMS_EXIT1_IR: tapNext = m ? BMS_UPD_IR : BMS_PAUSE_IR;
      BMS_PAUSE_IR: tapNext = m ? BMS_EXIT2_IR : BMS_PAUSE_IR;
      BMS_EXIT2_IR: tapNext = m ? BMS_UPD_IR : BMS_SHIFT_IR;
      BMS_UPD_IR: tapNext = m ? BMS_SEL_DR : BMS_RUN_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state of controller and chains
  always_comb
  begin
    next_prevTck = testClock;
    next_tapState = tapState;
    next_irShift = irShift;
    next_irHold = irHold;
    next_drShift = drShift;
    next_testDataOut = testDataOut;
    if (!testReset_n)
    begin
      // test reset forces the controller home at once
      next_tapState = BMS_TEST_RESET;
      next_irHold = BMS_IR_RESET;
    end
    else if (tckRise)
    begin
      next_tapState = tapNext(tapState, testModeSelect);
      unique case (tapState)
        BMS_CAP_IR: next_irShift = BMS_IR_RESET;
        BMS_SHIFT_IR:
        begin
          next_irShift = {testDataIn, irShift[IR_WIDTH-1:1]};
          next_testDataOut = irShift[0];
        end
        BMS_UPD_IR: next_irHold = irShift;
        BMS_SHIFT_DR:
        begin
          // bypass keeps a one-bit path, others use the full chain
          if (irHold == BMS_IR_BYPASS)
          begin
            next_drShift[0] = testDataIn;
            next_testDataOut = drShift[0];
          end
          else
          begin
            next_drShift = {testDataIn, drShift[DR_WIDTH-1:1]};
            next_testDataOut = drShift[0];
          end
        end
        BMS_TEST_RESET: next_irHold = BMS_IR_RESET;
        default:
        begin
          next_irShift = irShift;
        end
      endcase
    end
  end

  // registers of the controller
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // a floating test clock idles high, so a low reset value would fake an edge
      prevTck <= 1'h1;
      tapState <= BMS_TEST_RESET;
      irShift <= BMS_IR_RESET;
      irHold <= BMS_IR_RESET;
      drShift <= '0;
      testDataOut <= 1'h0;
    end
    else
    begin
      prevTck <= next_prevTck;
      tapState <= next_tapState;
      irShift <= next_irShift;
      irHold <= next_irHold;
      drShift <= next_drShift;
      testDataOut <= next_testDataOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_tap_reset: assert property (@(posedge clock) disable iff (rst)
    !testReset_n |=> tapState == BMS_TEST_RESET)
    else $error("tap not reset by test reset");
  chk_tap_hold: assert property (@(posedge clock) disable iff (rst)
    testReset_n && !tckRise |=> $stable(tapState))
    else $error("tap moved without test clock edge");
  chk_tap_stay: assert property (@(posedge clock) disable iff (rst)
    testReset_n && tckRise && testModeSelect && tapState == BMS_TEST_RESET
    |=> tapState == BMS_TEST_RESET)
    else $error("tap left reset with tms high");
  chk_chain_tdo: assert property (@(posedge clock) disable iff (rst)
    testReset_n && tckRise && tapState == BMS_SHIFT_DR && irHold != BMS_IR_BYPASS
    |=> testDataOut == $past(drShift[0]))
    else $error("tdo not from end of chain");
endmodule

// *** rtl/bms_strap_pin_config.sv ***
// Purpose: strap capture and pin function decode for the bridge mode block
// Assumes: all inputs synchronous to clock; board keeps straps stable
// Notes: straps latch on link reset release (forward) or bus reset release
`timescale 1ns/1ps
module bms_strap_pin_config
  import bms_pkg::*;
#(
  parameter int GPIO_COUNT = BMS_GPIO_COUNT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic linkReset_n,
  input wire logic busReset_n,
  input wire logic serial_iface_select,
  input wire logic normal_op_select,
  input wire logic bridge_direction,
  input wire logic hot_plug_enable_in,
  input wire logic [GPIO_COUNT-1:0] gpioOutEnable,
  input wire logic [GPIO_COUNT-1:0] gpioOutValue,
  input wire logic [GPIO_COUNT-1:0] gpioPinIn,
  output logic [GPIO_COUNT-1:0] gpioPinOut,
  output logic [GPIO_COUNT-1:0] gpioPinOe,
  output logic [GPIO_COUNT-1:0] gpioReadValue,
  input wire logic serialClockOut,
  input wire logic serialDataOut,
  input wire logic serialDataDrive,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic serialClockIn,
  output logic serialDataIn,
  input wire logic powerEventRequest,
  input wire logic power_event_request_n_in,
  output logic power_event_request_n,
  output logic power_event_request_n_oe,
  output logic smbusMode,
  output logic reverseMode,
  output logic normalOpStrap,
  output logic hotPlugEnable,
  input wire logic testClock,
  input wire logic testModeSelect,
  input wire logic testDataIn,
  input wire logic testReset_n,
  output logic testDataOut,
  output bms_tap_t tapState
);

  ////////////////////////////////////////////////////////////////////////
  logic prevLinkReset_n; // previous link reset level, for release edge
  logic prevBusReset_n; // previous bus reset level, for release edge
  logic next_prevLinkReset_n;
  logic next_prevBusReset_n;
  logic next_smbusMode;
  logic next_reverseMode;
  logic next_normalOpStrap;
  logic linkRelease; // one-cycle pulse on link reset release
  logic busRelease; // one-cycle pulse on bus reset release
  logic strapTake; // release edge of the reset that governs the mode

  assign linkRelease = linkReset_n && !prevLinkReset_n;
  assign busRelease = busReset_n && !prevBusReset_n;
  // the present mode decides which reset is watched; forward after reset
  assign strapTake = reverseMode ? busRelease : linkRelease;

  ////////////////////////////////////////////////////////////////////////
  // strap capture: values change only at a release edge
  always_comb
  begin
    next_prevLinkReset_n = linkReset_n;
    next_prevBusReset_n = busReset_n;
    next_smbusMode = smbusMode;
    next_reverseMode = reverseMode;
    next_normalOpStrap = normalOpStrap;
    if (strapTake)
    begin
      next_smbusMode = (serial_iface_select == BMS_IFACE_SMBUS);
      next_reverseMode = (bridge_direction == BMS_DIR_REVERSE);
      // the reserved high level is only reported, never acted on
      next_normalOpStrap = normal_op_select;
    end
  end

  // strap registers; reset comes up as eeprom, forward bridge
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prevLinkReset_n <= 1'h0;
      prevBusReset_n <= 1'h0;
      smbusMode <= BMS_IFACE_EEPROM;
      reverseMode <= BMS_DIR_FORWARD;
      normalOpStrap <= 1'h0;
    end
    else
    begin
      prevLinkReset_n <= next_prevLinkReset_n;
      prevBusReset_n <= next_prevBusReset_n;
      smbusMode <= next_smbusMode;
      reverseMode <= next_reverseMode;
      normalOpStrap <= next_normalOpStrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin registers: data outputs come from flip-flops
  logic [GPIO_COUNT-1:0] next_gpioPinOut;
  logic [GPIO_COUNT-1:0] next_gpioPinOe;
  logic [GPIO_COUNT-1:0] next_gpioReadValue;
  logic next_sclOut, next_sclOe, next_sdaOut, next_sdaOe;
  logic next_sclIn, next_sdaIn, next_pmeOut, next_pmeOe, next_hotPlug;

  // decode serial pin directions from the latched mode
  always_comb
  begin
    next_gpioPinOe = gpioOutEnable;
    next_gpioPinOut = gpioOutValue;
    // input-only pins read the pad, driven pins read back their own value
    next_gpioReadValue = (gpioPinIn & ~gpioOutEnable) | (gpioOutValue & gpioOutEnable);
    next_hotPlug = hot_plug_enable_in;
    if (smbusMode)
    begin
      // smbus slave: clock is input only, data pulls low only
      next_sclOut = 1'h0;
      next_sclOe = 1'h0;
      next_sdaOut = 1'h0;
      next_sdaOe = serialDataDrive && !serialDataOut;
    end
    else
    begin
      // eeprom master: drive clock, data driven both ways when owned
      next_sclOut = serialClockOut;
      next_sclOe = 1'h1;
      next_sdaOut = serialDataOut;
      next_sdaOe = serialDataDrive;
    end
    next_sclIn = smbusMode ? serial_clock_pin_in : serialClockOut;
    next_sdaIn = serial_data_pin_in;
    // power event pin is open drain, pulled low on request
    next_pmeOut = 1'h0;
    next_pmeOe = powerEventRequest;
  end

  // pin flip-flops; reset leaves every pin undriven, the eeprom clock included
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      gpioPinOut <= '0;
      gpioPinOe <= '0;
      gpioReadValue <= '0;
      serial_clock_pin_out <= 1'h0;
      serial_clock_pin_oe <= 1'h0;
      serial_data_pin_out <= 1'h0;
      serial_data_pin_oe <= 1'h0;
      serialClockIn <= 1'h0;
      serialDataIn <= 1'h0;
      power_event_request_n <= 1'h0;
      power_event_request_n_oe <= 1'h0;
      hotPlugEnable <= 1'h0;
    end
    else
    begin
      gpioPinOut <= next_gpioPinOut;
      gpioPinOe <= next_gpioPinOe;
      gpioReadValue <= next_gpioReadValue;
      serial_clock_pin_out <= next_sclOut;
      serial_clock_pin_oe <= next_sclOe;
      serial_data_pin_out <= next_sdaOut;
      serial_data_pin_oe <= next_sdaOe;
      serialClockIn <= next_sclIn;
      serialDataIn <= next_sdaIn;
      power_event_request_n <= next_pmeOut;
      power_event_request_n_oe <= next_pmeOe;
      hotPlugEnable <= next_hotPlug;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boundary scan controller
  bms_tap #(
    .IR_WIDTH(BMS_IR_WIDTH),
    .DR_WIDTH(BMS_DR_WIDTH)
  ) u_tap (
    .clock(clock),
    .rst(rst),
    .testClock(testClock),
    .testModeSelect(testModeSelect),
    .testDataIn(testDataIn),
    .testReset_n(testReset_n),
    .testDataOut(testDataOut),
    .tapState(tapState)
  );

  ////////////////////////////////////////////////////////////////////////
  sequence linkReleaseFwd;
    !reverseMode && linkReset_n && !prevLinkReset_n;
  endsequence

  chk_strap_iface: assert property (@(posedge clock) disable iff (rst)
    linkReleaseFwd |=> smbusMode == $past(serial_iface_select))
    else $error("interface strap not captured");
  chk_strap_dir: assert property (@(posedge clock) disable iff (rst)
    linkReleaseFwd |=> reverseMode == $past(bridge_direction))
    else $error("direction strap not captured");
  chk_strap_hold: assert property (@(posedge clock) disable iff (rst)
    !strapTake |=> $stable(smbusMode) && $stable(reverseMode))
    else $error("strap changed without reset release");
  chk_rev_ignore: assert property (@(posedge clock) disable iff (rst)
    reverseMode && !busRelease |=> reverseMode)
    else $error("reverse mode left without bus release");
  chk_gpio_dir: assert property (@(posedge clock) disable iff (rst)
    1'h1 |=> gpioPinOe == $past(gpioOutEnable))
    else $error("gpio enable not applied");
  chk_scl_dir: assert property (@(posedge clock) disable iff (rst)
    1'h1 |=> serial_clock_pin_oe == !$past(smbusMode))
    else $error("serial clock direction wrong");
  chk_sda_drain: assert property (@(posedge clock) disable iff (rst)
    smbusMode |=> !(serial_data_pin_oe && serial_data_pin_out))
    else $error("serial data driven high in smbus mode");
  chk_pme_req: assert property (@(posedge clock) disable iff (rst)
    powerEventRequest |=> power_event_request_n_oe && !power_event_request_n)
    else $error("power event not asserted");
endmodule

// *** dv/bms_board_model.sv ***
// Purpose: board side of the serial and power event pads, with smbus host
// Assumes: pads resolve combinationally from every party's enable
// Notes: a released data or power event line goes to its pull-up, never to its last value
`timescale 1ns/1ps
module bms_board_model
(
  input wire logic sclOut, // device clock drive
  input wire logic sclOe, // device clock enable
  input wire logic hostClock, // smbus host clock
  input wire logic sdaOut, // device data drive
  input wire logic sdaOe, // device data enable
  input wire logic hostDataLow, // host or eeprom pulls data low
  input wire logic pmeOut, // device power event drive
  input wire logic pmeOe, // device power event enable
  output logic sclPad, // resolved clock pad
  output logic sdaPad, // resolved data pad
  output logic pmePad // resolved power event pad
);
  // host clock reaches the pad only while the device leaves it
  assign sclPad = sclOe ? sclOut : hostClock;
  // data has a pull-up, so both parties form a wired-and
  assign sdaPad = (sdaOe ? sdaOut : 1'b1) & ~hostDataLow;
  // power event line is pulled up when nobody sinks it
  assign pmePad = pmeOe ? pmeOut : 1'b1;
endmodule

// *** dv/bms_strap_pin_config_tb.sv ***
// Purpose: self-checking bench for strap capture, pin decode and the tap
// Assumes: inputs change at the falling edge, outputs read there too
// Notes: random pin values come from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module bms_strap_pin_config_tb;
  import bms_pkg::*;
  localparam int LIMIT = 2000; // about five times the expected run
  logic clock, rst, linkReset_n, busReset_n;
  logic serial_iface_select, normal_op_select, bridge_direction, hot_plug_enable_in;
  logic [BMS_GPIO_COUNT-1:0] gpioOutEnable, gpioOutValue, gpioPinIn;
  logic [BMS_GPIO_COUNT-1:0] gpioPinOut, gpioPinOe, gpioReadValue;
  logic serialClockOut, serialDataOut, serialDataDrive, serialClockIn, serialDataIn;
  logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
  logic serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe;
  logic powerEventRequest, power_event_request_n_in;
  logic power_event_request_n, power_event_request_n_oe;
  logic smbusMode, reverseMode, normalOpStrap, hotPlugEnable;
  logic testClock, testModeSelect, testDataIn, testReset_n, testDataOut;
  logic hostClock, hostDataLow, curRev, curIfc; // cur*: straps we expect latched
  logic [7:0] d; // data pushed through the scan chain
  bms_tap_t tapState;
  int nFail, checksDone, cycles;
  // tap walk that visits all sixteen states
  logic [19:0] walkTms = 20'hed3d2;
  // tms for the bypass load, lsb first: stay in reset once, load ir, enter shift-dr
  logic [13:0] bypassTms = 14'h0e0d;
  bms_tap_t walk [20] = '{BMS_RUN_IDLE, BMS_SEL_DR, BMS_CAP_DR, BMS_SHIFT_DR,
    BMS_EXIT1_DR, BMS_PAUSE_DR, BMS_EXIT2_DR, BMS_UPD_DR, BMS_SEL_DR, BMS_SEL_IR,
    BMS_CAP_IR, BMS_SHIFT_IR, BMS_EXIT1_IR, BMS_PAUSE_IR, BMS_EXIT2_IR, BMS_UPD_IR,
    BMS_RUN_IDLE, BMS_SEL_DR, BMS_SEL_IR, BMS_TEST_RESET};
  //////////////////////////////////////////////////////////////////////////////
  bms_strap_pin_config dut
  (
    .clock, .rst, .linkReset_n, .busReset_n, .serial_iface_select, .normal_op_select,
    .bridge_direction, .hot_plug_enable_in, .gpioOutEnable, .gpioOutValue, .gpioPinIn,
    .gpioPinOut, .gpioPinOe, .gpioReadValue, .serialClockOut, .serialDataOut,
    .serialDataDrive, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
    .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe, .serialClockIn,
    .serialDataIn, .powerEventRequest, .power_event_request_n_in, .power_event_request_n,
    .power_event_request_n_oe, .smbusMode, .reverseMode, .normalOpStrap, .hotPlugEnable,
    .testClock, .testModeSelect, .testDataIn, .testReset_n, .testDataOut, .tapState
  );
  bms_board_model board
  (
    .sclOut(serial_clock_pin_out), .sclOe(serial_clock_pin_oe), .hostClock(hostClock),
    .sdaOut(serial_data_pin_out), .sdaOe(serial_data_pin_oe), .hostDataLow(hostDataLow),
    .pmeOut(power_event_request_n), .pmeOe(power_event_request_n_oe),
    .sclPad(serial_clock_pin_in), .sdaPad(serial_data_pin_in),
    .pmePad(power_event_request_n_in)
  );
  //////////////////////////////////////////////////////////////////////////////
  // free-running clock, 4 ns period
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // hang guard: a run past the limit is a failure
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      nFail++;
      closeOut();
    end
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // let n rising edges pass, then return at a falling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // low pulse on the reset that owns the strap capture in the given mode
  task automatic pulseReset(input logic useBus);
    if (useBus)
      busReset_n = 1'b0;
    else
      linkReset_n = 1'b0;
    tick(2);
    linkReset_n = 1'b1;
    busReset_n = 1'b1;
    tick(2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic strap(input logic s, input logic r);
    serial_iface_select = s;
    bridge_direction = r;
    normal_op_select = 1'b0;
    pulseReset(curRev);
    `CHK("smbusMode", s, smbusMode);
    `CHK("reverseMode", r, reverseMode);
    `CHK("normalOpStrap", 1'b0, normalOpStrap);
    curRev = r;
    curIfc = s;
    // straps flip here only to show that the other reset cannot reload them
    serial_iface_select = ~s;
    bridge_direction = ~r;
    pulseReset(~curRev);
    `CHK("smbusHeld", s, smbusMode);
    `CHK("reverseHeld", r, reverseMode);
    serial_iface_select = s;
    bridge_direction = r;
  endtask
  // expected data enable: open drain in smbus mode, plain enable otherwise
  function automatic logic expSdaOe(input logic ifc, input logic drv, input logic dat);
    return ifc ? (drv & ~dat) : drv;
  endfunction
  // random pin traffic, held three cycles so pads and read-backs settle
  task automatic pinsRand(input int k);
    logic oe, out, pad;
    logic [3:0] rd;
    gpioOutEnable = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : 4'($urandom);
    gpioOutValue = 4'($urandom);
    gpioPinIn = 4'($urandom);
    {serialClockOut, serialDataOut, serialDataDrive} = 3'($urandom);
    {hostClock, hostDataLow, powerEventRequest, hot_plug_enable_in} = 4'($urandom);
    tick(3);
    oe = expSdaOe(curIfc, serialDataDrive, serialDataOut);
    out = curIfc ? 1'b0 : serialDataOut;
    pad = (oe ? out : 1'b1) & ~hostDataLow;
    rd = (gpioOutEnable & gpioOutValue) | (~gpioOutEnable & gpioPinIn);
    `CHK("gpioPinOe", gpioOutEnable, gpioPinOe);
    `CHK("gpioPinOut", gpioOutValue & gpioOutEnable, gpioPinOut & gpioOutEnable);
    `CHK("gpioReadValue", rd, gpioReadValue);
    `CHK("sclOe", ~curIfc, serial_clock_pin_oe);
    `CHK("sclIn", curIfc ? hostClock : serialClockOut, serialClockIn);
    if (!curIfc) `CHK("sclOut", serialClockOut, serial_clock_pin_out);
    `CHK("sdaOe", oe, serial_data_pin_oe);
    if (oe) `CHK("sdaOut", out, serial_data_pin_out);
    `CHK("sdaIn", pad, serialDataIn);
    `CHK("pmeOe", powerEventRequest, power_event_request_n_oe);
    `CHK("pmePad", ~powerEventRequest, power_event_request_n_in);
    `CHK("hotPlug", hot_plug_enable_in, hotPlugEnable);
  endtask
  // one full test clock period, tms and tdi set with the rising edge
  task automatic tckStep(input logic tms, input logic tdi);
    testClock = 1'b0;
    tick(2);
    testClock = 1'b1;
    testModeSelect = tms;
    testDataIn = tdi;
    tick(2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, linkReset_n, busReset_n, curRev, curIfc} = 5'h10;
    {serial_iface_select, normal_op_select, bridge_direction, hot_plug_enable_in} = 4'h0;
    {gpioOutEnable, gpioOutValue, gpioPinIn} = 12'h000;
    {serialClockOut, serialDataOut, serialDataDrive, powerEventRequest} = 4'h0;
    {hostClock, hostDataLow, testClock, testDataIn} = 4'h0;
    testModeSelect = 1'b0;
    testReset_n = 1'b0;
    {nFail, checksDone, cycles} = '0;
    void'($urandom(32'h41f33703));
    tick(20);
    rst = 1'b0;
    tick(1);
    `CHK("rstSmbus", 1'b0, smbusMode);
    `CHK("rstReverse", 1'b0, reverseMode);
    `CHK("rstTap", BMS_TEST_RESET, tapState);
    $display("test reset done");
    // every interface and direction strap combination, each followed by pin traffic in that mode
    for (int i = 0; i < 5; i++)
    begin
      strap(5'b00110 >> i, 5'b01100 >> i);
      for (int k = 0; k < 8; k++)
        pinsRand(k);
    end
    $display("test straps and pins done");
    testReset_n = 1'b1;
    d = 8'($urandom);
    tick(2);
    for (int i = 0; i < 20; i++)
    begin
      if (i == 4)
        for (int k = 0; k < 16; k++)
        begin
          tckStep(1'b0, d[k % 8]);
          if (k >= 8) `CHK("testDataOut", d[k - 8], testDataOut);
        end
      tckStep(walkTms[i], 1'b0);
      `CHK("tapState", walk[i], tapState);
    end
    // bypass: ones shifted into the instruction, then a one-stage data path
    for (int k = 0; k < 14; k++)
    begin
      tckStep(bypassTms[k], 1'b1);
      if (k == 0) `CHK("tapStay", BMS_TEST_RESET, tapState);
      if (k >= 6 && k <= 9) `CHK("irOut", BMS_IR_RESET[k - 6], testDataOut);
    end
    `CHK("bypassState", BMS_SHIFT_DR, tapState);
    for (int k = 0; k < 8; k++)
    begin
      tckStep(1'b0, d[k]);
      if (k >= 1) `CHK("bypassOut", d[k - 1], testDataOut);
    end
    // test reset in mid-run must win over the walk
    tckStep(1'b0, 1'b0);
    testReset_n = 1'b0;
    tick(2);
    `CHK("tapReset", BMS_TEST_RESET, tapState);
    $display("test tap done");
    closeOut();
  end
endmodule
